// file: verilog/spsel_cfg.svh
// Register offsets, field positions, reset values and event bits for the status pin selector.
`ifndef SPSEL_CFG_SVH
`define SPSEL_CFG_SVH
`define SPSEL_ADDR_W 8
`define SPSEL_OFF_CONFIG 8'h1C
`define SPSEL_OFF_IRQ_STATUS 8'h40
`define SPSEL_OFF_IRQ_ENABLE 8'h44
`define SPSEL_OFF_IRQ_CLEAR 8'h48
`define SPSEL_OFF_TEST_CTRL 8'h4C
`define SPSEL_SEL_MSB 7
`define SPSEL_SEL_LSB 4
`define SPSEL_POL_BIT 3
`define SPSEL_SEL_RESET 4'h2
`define SPSEL_POL_RESET 1'b1
`define SPSEL_NUM_EVENTS 4
`define SPSEL_EV_PIN_RISE 0
`define SPSEL_EV_PIN_FALL 1
`define SPSEL_EV_CFG_WRITE 2
`define SPSEL_EV_TEST_ENTER 3
`endif

// file: verilog/spsel_pkg.sv
// Types shared by the status pin selector.
package spsel_pkg;
    // Selectable indicator codes.
    typedef enum logic [3:0] {
        SRC_PRI_LOSS = 4'h0,
        SRC_SEC_LOSS = 4'h1,
        SRC_S1_LOCK_LOSS = 4'h2,
        SRC_S1_REF_DIV = 4'h3,
        SRC_S1_FB_DIV = 4'h4,
        SRC_S2_LOCK_LOSS = 4'h5,
        SRC_S2_REF_DIV = 4'h6,
        SRC_S2_FB_DIV = 4'h7,
        SRC_S1_CAL = 4'h8,
        SRC_S2_CAL = 4'h9,
        SRC_IRQ_SUM = 4'hA,
        SRC_S1_M_DIV = 4'hB,
        SRC_S2_M_DIV = 4'hC,
        SRC_NVM = 4'hD,
        SRC_S1_REVERT = 4'hE,
        SRC_S2_REVERT = 4'hF
    } spsel_src_e;

    // Raw indicators from the surrounding device.
    typedef struct packed {
        logic primary_loss;
        logic secondary_loss;
        logic s1_lock_loss;
        logic s2_lock_loss;
        logic s1_cal;
        logic s2_cal;
        logic nvm_active;
        logic s1_revert;
        logic s2_revert;
    } spsel_levels_s;

    // Divider output pulses (one cycle each) and bypass flags.
    typedef struct packed {
        logic s1_ref_pulse;
        logic s2_ref_pulse;
        logic s1_fb_pulse;
        logic s2_fb_pulse;
        logic s1_m_pulse;
        logic s2_m_pulse;
        logic s1_ref_bypass;
        logic s2_ref_bypass;
        logic s1_m_bypass;
        logic s2_m_bypass;
    } spsel_divs_s;

    // Test override request.
    typedef struct packed {
        logic active;
        logic value;
    } spsel_test_s;
endpackage

// file: verilog/spsel_status_pin.sv
// Source selector and polarity control for the second status pin.
`timescale 1ns/1ps
`include "spsel_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation.
//
// The block owns one configuration byte that picks which internal indicator
// reaches the second status pin and with which polarity.
// Bits 7:4 hold the source code, bit 3 holds the polarity and bits 2:0 are
// reserved, so they are dropped on a write and always read back as zero.
// After reset the byte reads 0x28: synth one lock loss, shown active high.
//
// Indicator levels arrive from other parts of the device that do not share
// this clock, so each one passes three flip-flops.
// A new level is only accepted once the second and third stages agree.
// This filters a single-cycle glitch at the cost of one extra cycle of delay.
// From a change at the input to the pin the path is about five edges long.
//
// Divider outputs arrive as one-cycle pulses on this clock.
// Each divider owns a toggle flip-flop that flips on every pulse, so the pin
// shows a square wave at half the pulse rate.
// A bypassed reference or M divider holds its toggle at zero.
// A user must know that a bypassed divider then shows a steady inactive level.
// The feedback dividers have no bypass, so their toggles always run.
// All six toggles run whether or not they are selected.
// That keeps the phase of each toggle independent of the select history.
//
// The interrupt summary is the OR of the flag bits that their mask lets pass.
// It comes from logic on this clock and needs no synchroniser.
//
// Test settings win over the selection whenever they are active.
// The external test request wins over the register override.
// Both drive the raw value, with no polarity applied, since a diagnostic
// wants to see exactly the level it asked for.
//
// The pin and the interrupt line leave straight from flip-flops, so the board
// never sees a combinational glitch when the select code changes.
// A change of code reaches the pin at the second edge after the write.
//
// Register map on the byte-wide port:
// 0x1C configuration: source code, polarity, reserved zeros.
// 0x40 status, read only: pin rise, pin fall, config write, test entry.
// 0x44 enable, read and write, same layout as status.
// 0x48 clear, write only, a one clears the matching status bit.
// 0x4C test control: override enable, override value, override active.
//
// Read data stand for one cycle after the read strobe and are zero otherwise.
// Unmapped addresses read as zero and ignore writes.
// The port never inserts wait states, so strobes may follow back to back.
//
// Status bits are sticky and a new event beats a clear in the same cycle.
// Losing an event would hide a pin edge from software, while a spurious
// status bit only costs one extra service pass.
// The interrupt line is high while any enabled status bit is set.
////////////////////////////////////////////////////////////////////////////////

module spsel_status_pin #(
    parameter int FLAG_W = 8
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [`SPSEL_ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire spsel_pkg::spsel_levels_s i_levels,
    input wire spsel_pkg::spsel_divs_s i_divs,
    input wire logic [FLAG_W-1:0] i_int_flags,
    input wire logic [FLAG_W-1:0] i_int_mask,
    input wire spsel_pkg::spsel_test_s i_test,
    output logic o_status_pin_b,
    output logic o_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin-side synchronisers for indicator levels (three stages, vote of 2 and 3).
    localparam int NLV = $bits(spsel_pkg::spsel_levels_s);
    logic [NLV-1:0] lv_s1_q, lv_s2_q, lv_s3_q, lv_q;
    logic [NLV-1:0] lv_d;

    // Stable level taken once the second and third stages agree.
    always_comb begin
        lv_d = lv_q;
        for (int k = 0; k < NLV; k++) begin
            if (lv_s2_q[k] == lv_s3_q[k]) begin
                lv_d[k] = lv_s2_q[k];
            end
        end
    end

    // Registers the synchroniser chain.
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            lv_s1_q <= '0;
            lv_s2_q <= '0;
            lv_s3_q <= '0;
            lv_q <= '0;
        end else begin
            lv_s1_q <= i_levels;
            lv_s2_q <= lv_s1_q;
            lv_s3_q <= lv_s2_q;
            lv_q <= lv_d;
        end
    end

    spsel_pkg::spsel_levels_s lv;
    assign lv = spsel_pkg::spsel_levels_s'(lv_q);

    ////////////////////////////////////////////////////////////////////////////
    // Divide-by-two toggles, one per divider output pulse.
    logic [5:0] div_pulse;
    logic [5:0] div_bypass;
    logic [5:0] half_q;
    logic [5:0] half_d;
    assign div_pulse = {i_divs.s2_m_pulse, i_divs.s1_m_pulse, i_divs.s2_fb_pulse,
                        i_divs.s1_fb_pulse, i_divs.s2_ref_pulse, i_divs.s1_ref_pulse};
    assign div_bypass = {i_divs.s2_m_bypass, i_divs.s1_m_bypass, 1'b0, 1'b0,
                         i_divs.s2_ref_bypass, i_divs.s1_ref_bypass};

    // Each toggle flips on its divider pulse; a bypassed divider holds it low.
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_half
            always_comb begin
                if (div_bypass[g]) begin
                    half_d[g] = 1'b0;
                end else if (div_pulse[g]) begin
                    half_d[g] = ~half_q[g];
                end else begin
                    half_d[g] = half_q[g];
                end
            end
        end
    endgenerate

    // Registers the divide-by-two toggles.
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            half_q <= '0;
        end else begin
            half_q <= half_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration, test and interrupt registers.
    logic [3:0] sel_q, sel_d;
    logic pol_q, pol_d;
    logic tst_en_q, tst_en_d;
    logic tst_val_q, tst_val_d;
    logic [`SPSEL_NUM_EVENTS-1:0] ist_q, ist_d, ien_q, ien_d;
    logic [7:0] rdata_q, rdata_d;
    logic pin_q, pin_d;
    logic irq_q, irq_d;
    logic test_on_q, test_on_d;
    logic wr_cfg, wr_tst;
    logic [`SPSEL_NUM_EVENTS-1:0] ev;

    assign wr_cfg = i_wr && (i_addr == `SPSEL_OFF_CONFIG);
    assign wr_tst = i_wr && (i_addr == `SPSEL_OFF_TEST_CTRL);

    // Register writes and read-data mux.
    always_comb begin
        sel_d = sel_q;
        pol_d = pol_q;
        tst_en_d = tst_en_q;
        tst_val_d = tst_val_q;
        ien_d = ien_q;
        rdata_d = 8'h00;
        if (wr_cfg) begin
            sel_d = i_wdata[`SPSEL_SEL_MSB:`SPSEL_SEL_LSB];
            pol_d = i_wdata[`SPSEL_POL_BIT];
        end
        if (wr_tst) begin
            tst_en_d = i_wdata[0];
            tst_val_d = i_wdata[1];
        end
        if (i_wr && (i_addr == `SPSEL_OFF_IRQ_ENABLE)) begin
            ien_d = i_wdata[`SPSEL_NUM_EVENTS-1:0];
        end
        if (i_rd) begin
            case (i_addr)
                `SPSEL_OFF_CONFIG: rdata_d = {sel_q, pol_q, 3'h0};
                `SPSEL_OFF_IRQ_STATUS: rdata_d = {4'h0, ist_q};
                `SPSEL_OFF_IRQ_ENABLE: rdata_d = {4'h0, ien_q};
                `SPSEL_OFF_TEST_CTRL: rdata_d = {5'h00, test_on_q, tst_val_q, tst_en_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Indicator selection, polarity, test override and interrupt events.
    logic int_summary;
    logic ind;
    logic test_active;
    assign int_summary = |(i_int_flags & i_int_mask);
    assign test_active = tst_en_q | i_test.active;

    // Chooses the indicator, applies polarity, lets test settings win.
    always_comb begin
        case (spsel_pkg::spsel_src_e'(sel_q))
            spsel_pkg::SRC_PRI_LOSS: ind = lv.primary_loss;
            spsel_pkg::SRC_SEC_LOSS: ind = lv.secondary_loss;
            spsel_pkg::SRC_S1_LOCK_LOSS: ind = lv.s1_lock_loss;
            spsel_pkg::SRC_S2_LOCK_LOSS: ind = lv.s2_lock_loss;
            spsel_pkg::SRC_S1_REF_DIV: ind = half_q[0];
            spsel_pkg::SRC_S2_REF_DIV: ind = half_q[1];
            spsel_pkg::SRC_S1_FB_DIV: ind = half_q[2];
            spsel_pkg::SRC_S2_FB_DIV: ind = half_q[3];
            spsel_pkg::SRC_S1_M_DIV: ind = half_q[4];
            spsel_pkg::SRC_S2_M_DIV: ind = half_q[5];
            spsel_pkg::SRC_S1_CAL: ind = lv.s1_cal;
            spsel_pkg::SRC_S2_CAL: ind = lv.s2_cal;
            spsel_pkg::SRC_NVM: ind = lv.nvm_active;
            spsel_pkg::SRC_S1_REVERT: ind = lv.s1_revert;
            spsel_pkg::SRC_S2_REVERT: ind = lv.s2_revert;
            spsel_pkg::SRC_IRQ_SUM: ind = int_summary;
            default: ind = 1'b0;
        endcase
        if (test_active) begin
            pin_d = i_test.active ? i_test.value : tst_val_q;
        end else begin
            pin_d = pol_q ? ind : ~ind;
        end
        test_on_d = test_active;
    end

    // Events: pin edges, config write and entry into test override.
    assign ev[`SPSEL_EV_PIN_RISE] = pin_d & ~pin_q;
    assign ev[`SPSEL_EV_PIN_FALL] = ~pin_d & pin_q;
    assign ev[`SPSEL_EV_CFG_WRITE] = wr_cfg;
    assign ev[`SPSEL_EV_TEST_ENTER] = test_active & ~test_on_q;

    // Sticky status: a clear write loses against a new event in the same cycle.
    always_comb begin
        ist_d = ist_q;
        if (i_wr && (i_addr == `SPSEL_OFF_IRQ_CLEAR)) begin
            ist_d = ist_q & ~i_wdata[`SPSEL_NUM_EVENTS-1:0];
        end
        ist_d = ist_d | ev;
        irq_d = |(ist_d & ien_d);
    end

    // Registers all configuration, status and output state.
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            sel_q <= `SPSEL_SEL_RESET;
            pol_q <= `SPSEL_POL_RESET;
            tst_en_q <= 1'b0;
            tst_val_q <= 1'b0;
            ien_q <= '0;
            ist_q <= '0;
            rdata_q <= 8'h00;
            pin_q <= 1'b0;
            irq_q <= 1'b0;
            test_on_q <= 1'b0;
        end else begin
            sel_q <= sel_d;
            pol_q <= pol_d;
            tst_en_q <= tst_en_d;
            tst_val_q <= tst_val_d;
            ien_q <= ien_d;
            ist_q <= ist_d;
            rdata_q <= rdata_d;
            pin_q <= pin_d;
            irq_q <= irq_d;
            test_on_q <= test_on_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_status_pin_b = pin_q;
    assign o_irq = irq_q;

endmodule

// file: verification/spsel_board_mon.sv
// Board-side monitor that counts rising steps on the status pin.
`timescale 1ns/1ps
module spsel_board_mon (
    input wire logic i_clk,
    input wire logic i_clear,
    input wire logic i_pin,
    output logic [7:0] o_rises
);
    logic last_q;
    // The board samples the pin on its own clock and counts low-to-high steps.
    always_ff @(posedge i_clk) begin
        last_q <= i_pin;
        if (i_clear) begin
            o_rises <= 8'h00;
        end else if (i_pin && !last_q) begin
            o_rises <= o_rises + 8'h01;
        end
    end
endmodule

// file: verification/spsel_status_pin_assertions.sv
// Port-level checks of the status pin selector.
`timescale 1ns/1ps
`include "spsel_cfg.svh"
module spsel_status_pin_assertions #(
    parameter int FLAG_W = 8
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [`SPSEL_ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire spsel_pkg::spsel_levels_s i_levels,
    input wire spsel_pkg::spsel_divs_s i_divs,
    input wire logic [FLAG_W-1:0] i_int_flags,
    input wire logic [FLAG_W-1:0] i_int_mask,
    input wire spsel_pkg::spsel_test_s i_test,
    input wire logic o_status_pin_b,
    input wire logic o_irq
);
    // Per-code masks, one bit per select code, and bit-index tables, one nibble per select code.
    localparam logic [15:0] LVM = 16'hE327;
    localparam logic [15:0] DVM = 16'h18D8;
    localparam logic [15:0] BPM = 16'h1848;
    localparam logic [63:0] LVT = 64'h0120_0034_0050_0678;
    localparam logic [63:0] DVT = 64'h0004_5000_6807_9000;
    localparam logic [63:0] BPT = 64'h0000_1000_0200_3000;
    logic [7:0] cfg_q;
    logic ovr_q;
    logic [3:0] sl;
    logic lv, pv, bp, smd, nrm;
    // Shadows of the configuration and override bits as software wrote them.
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            cfg_q <= 8'h28;
            ovr_q <= 1'b0;
        end else if (i_wr && i_addr == `SPSEL_OFF_CONFIG) begin
            cfg_q <= {i_wdata[7:3], 3'h0};
        end else if (i_wr && i_addr == `SPSEL_OFF_TEST_CTRL) begin
            ovr_q <= i_wdata[0];
        end
    end
    // Expected source for the current select code.
    always_comb begin
        sl = cfg_q[7:4];
        lv = i_levels[LVT[{sl, 2'b00} +: 4]];
        pv = i_divs[DVT[{sl, 2'b00} +: 4]];
        bp = BPM[sl] && i_divs[BPT[{sl, 2'b00} +: 4]];
        smd = (|(i_int_flags & i_int_mask)) ~^ cfg_q[3];
        nrm = !i_test.active && !ovr_q;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    a_read_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside answer");
    a_cfg_read: assert property ($past(i_rd && i_addr == `SPSEL_OFF_CONFIG) |->
        o_rdata == $past(cfg_q)) else $error("config readback wrong");
    a_reset_out: assert property ($rose(i_resetn) |-> !o_status_pin_b && !o_irq)
        else $error("outputs not low after reset");
    a_test_wins: assert property (i_test.active |=> o_status_pin_b == $past(i_test.value))
        else $error("test override ignored");
    a_interrupt_summary_path: assert property (sl == 4'hA && nrm |=> o_status_pin_b == $past(smd))
        else $error("summary not on pin");
    a_level_path: assert property ((LVM[sl] && nrm && $stable(lv) && $stable(cfg_q))[*8]
        |-> o_status_pin_b == (lv ~^ cfg_q[3])) else $error("level source wrong");
    a_div_quiet: assert property ((DVM[sl] && nrm && !pv && $stable({cfg_q, i_divs[3:0]}))[*6]
        |=> $stable(o_status_pin_b)) else $error("divider pin moved without pulse");
    a_bypass_low: assert property ((bp && nrm && $stable(cfg_q))[*6]
        |-> o_status_pin_b == !cfg_q[3]) else $error("bypassed divider not idle");
    c_summary: cover property (sl == 4'hA && nrm);
    c_test: cover property (i_test.active);
    c_bypass: cover property (bp);
endmodule
bind spsel_status_pin spsel_status_pin_assertions #(.FLAG_W(FLAG_W)) u_chk (.*);

// file: verification/spsel_status_pin_bench.sv
// Register-level tests of the status pin selector.
`timescale 1ns/1ps
`include "spsel_cfg.svh"
module spsel_status_pin_bench;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic mon_clr = 1'b0;
    spsel_pkg::spsel_levels_s i_levels = '0;
    spsel_pkg::spsel_divs_s i_divs = '0;
    logic [7:0] i_int_flags = 8'h00;
    logic [7:0] i_int_mask = 8'h00;
    spsel_pkg::spsel_test_s i_test = '0;
    logic [7:0] o_rdata, rises;
    logic o_status_pin_b, o_irq;
    logic [9:0] dv;
    int mismatches = 0;
    int checks = 0;
    logic [3:0] lcd [9] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h8, 4'h9, 4'hD, 4'hE, 4'hF};
    logic [3:0] dcd [6] = '{4'h3, 4'h4, 4'h6, 4'h7, 4'hB, 4'hC};
    int dbit [6] = '{9, 7, 8, 6, 5, 4};
    // Clock at 50 MHz.
    always #10 i_clk = ~i_clk;
    spsel_status_pin dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_levels(i_levels),
        .i_divs(i_divs), .i_int_flags(i_int_flags), .i_int_mask(i_int_mask),
        .i_test(i_test), .o_status_pin_b(o_status_pin_b), .o_irq(o_irq));
    spsel_board_mon mon (.i_clk(i_clk), .i_clear(mon_clr), .i_pin(o_status_pin_b),
        .o_rises(rises));
    // Comparison, bus cycles and pin sampling.
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, e);
    endtask
    task automatic pin(input int n, input logic e);
        repeat (n) @(posedge i_clk);
        #1 chk({7'h00, o_status_pin_b}, {7'h00, e});
        @(posedge i_clk);
    endtask
    task automatic give_verdict;
        if (mismatches == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Main sequence: reset, registers, sources, summary, override, interrupt.
    initial begin
        repeat (6) @(posedge i_clk);
        i_resetn <= 1'b1;
        rd(`SPSEL_OFF_CONFIG, 8'h28);
        wr(`SPSEL_OFF_CONFIG, 8'hFF);
        rd(`SPSEL_OFF_CONFIG, 8'hF8);
        rd(8'h10, 8'h00);
        for (int i = 0; i < 18; i++) begin
            wr(`SPSEL_OFF_CONFIG, {lcd[i/2], i[0], 3'h0});
            i_levels <= 9'h001 << (8 - i / 2);
            pin(9, i[0]);
            i_levels <= ~(9'h001 << (8 - i / 2));
            pin(9, !i[0]);
        end
        for (int i = 0; i < 12; i++) begin
            wr(`SPSEL_OFF_CONFIG, {dcd[i%6], 4'h8});
            i_divs <= {6'h00, (i > 5) ? 4'hF : 4'h0};
            repeat (5) @(posedge i_clk);
            mon_clr <= 1'b1;
            @(posedge i_clk);
            mon_clr <= 1'b0;
            for (int k = 0; k < 12; k++) begin
                @(posedge i_clk);
                dv = {(k % 2 == 0) ? 6'h3F : 6'h00, (i > 5) ? 4'hF : 4'h0};
                dv[dbit[i%6]] = (k % 3 == 0);
                i_divs <= dv;
            end
            @(posedge i_clk);
            i_divs <= {6'h00, (i > 5) ? 4'hF : 4'h0};
            repeat (6) @(posedge i_clk);
            #1 chk(rises, (i > 5 && i != 7 && i != 9) ? 8'h00 : 8'h02);
        end
        wr(`SPSEL_OFF_CONFIG, 8'hA8);
        i_int_flags <= 8'h10;
        pin(3, 1'b0);
        i_int_mask <= 8'h10;
        pin(2, 1'b1);
        i_test <= 2'b10;
        pin(2, 1'b0);
        i_test <= 2'b00;
        pin(2, 1'b1);
        wr(`SPSEL_OFF_TEST_CTRL, 8'h01);
        pin(3, 1'b0);
        wr(`SPSEL_OFF_TEST_CTRL, 8'h00);
        wr(`SPSEL_OFF_IRQ_ENABLE, 8'h00);
        wr(`SPSEL_OFF_IRQ_CLEAR, 8'h0F);
        wr(`SPSEL_OFF_CONFIG, 8'hA8);
        rd(`SPSEL_OFF_IRQ_STATUS, 8'h04);
        chk({7'h00, o_irq}, 8'h00);
        wr(`SPSEL_OFF_IRQ_ENABLE, 8'h04);
        rd(`SPSEL_OFF_IRQ_ENABLE, 8'h04);
        chk({7'h00, o_irq}, 8'h01);
        wr(`SPSEL_OFF_IRQ_CLEAR, 8'h04);
        rd(`SPSEL_OFF_IRQ_STATUS, 8'h00);
        chk({7'h00, o_irq}, 8'h00);
        give_verdict;
    end
    // Watchdog well beyond the expected run length.
    initial begin
        repeat (6000) @(posedge i_clk);
        mismatches++;
        give_verdict;
    end
endmodule
